// ==== hdl/opl_pkg.sv ====
// Constants, types and helpers for the output protection controller
package opl_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam real CLK_PERIOD_NS = 25.0;
    localparam real TICK_PERIOD_S = 0.001;
    localparam int TICK_CYCLES = int'(TICK_PERIOD_S * 1.0e9 / CLK_PERIOD_NS);
    localparam real DELAY_NORMAL_S = 0.08;
    localparam real DELAY_MAX_S = 2147483.647;
    localparam int DELAY_W = 31;
    localparam logic [30:0] DELAY_RESET =
        31'(int'(DELAY_NORMAL_S / TICK_PERIOD_S));
    localparam logic [30:0] DELAY_MAX = 31'(int'(DELAY_MAX_S / TICK_PERIOD_S));

    ////////////////////////////////////////////////////////////////////////
    // Channels and levels
    localparam int NUM_CH = 2;
    localparam int NUM_CH_MAX = 4;
    localparam int LEVEL_W = 16;
    localparam logic [15:0] LEVEL_MAX = 16'hffff;
    localparam logic [15:0] LEVEL_RESET = LEVEL_MAX / 16'h000a;

    ////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses)
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_DELAY = 6'h04;
    localparam logic [5:0] OFS_CMD = 6'h08;
    localparam logic [5:0] OFS_STATUS = 6'h0c;
    localparam logic [5:0] OFS_IRQ_STAT = 6'h10;
    localparam logic [5:0] OFS_IRQ_CLR = 6'h14;
    localparam logic [5:0] OFS_IRQ_EN = 6'h18;
    localparam logic [5:0] OFS_LEVEL = 6'h20;
    localparam logic [5:0] LEVEL_STRIDE = 6'h08;
    localparam logic [5:0] PEND_OFS = 6'h04;

    localparam int CTRL_OCP_EN = 0;
    localparam int CTRL_MODE = 1;
    localparam int CTRL_OUT_ON = 3;
    localparam int CMD_CLEAR = 0;
    localparam int CMD_ARM = 1;
    localparam int ST_OUT_EN = 0;
    localparam int ST_OC = 1;
    localparam int ST_OV = 2;
    localparam int ST_INH_LATCH = 3;
    localparam int ST_INH_IN = 4;
    localparam int ST_ARMED = 5;
    localparam int ST_CC = 8;
    localparam int EV_CC = 0;
    localparam int EV_OC = 1;
    localparam int EV_INH = 2;
    localparam int EV_TRIG = 3;
    localparam int EV_W = 4;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {RI_OFF, RI_LIVE, RI_LATCH} opl_ri_mode_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [5:0] address;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } opl_avs_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } opl_avs_rsp_t;

    function automatic opl_ri_mode_t to_mode(input logic [1:0] v);
        unique case (v)
            2'h1: return RI_LIVE;
            2'h2: return RI_LATCH;
            default: return RI_OFF;
        endcase
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

endpackage

// ==== hdl/opl_cc_delay.sv ====
// Qualifying delay for one channel's constant-current indication
`timescale 1ns/1ps
module opl_cc_delay (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_tick,
    input wire logic i_restart,
    input wire logic i_cc,
    input wire logic [opl_pkg::DELAY_W-1:0] i_delay,
    output logic o_rec
);
    import opl_pkg::*;

    typedef struct packed {
        logic [DELAY_W:0] cnt;
        logic rec;
    } opl_dly_st_t;

    opl_dly_st_t q;
    opl_dly_st_t d;

    // Counting strictly past the delay makes a partial first tick harmless,
    // so the wait is never shorter than programmed
    always_comb begin
        d = q;
        if (i_restart || !i_cc) begin
            d.cnt = '0;
            d.rec = 1'b0;
        end else if (!q.rec) begin
            if (i_delay == '0 || q.cnt > {1'b0, i_delay}) begin
                d.rec = 1'b1;
            end else if (i_tick) begin
                d.cnt = (DELAY_W+1)'(q.cnt + 1'b1);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_rec = q.rec;

endmodule // opl_cc_delay

// ==== hdl/opl_level_slot.sv ====
// Immediate and pending current levels of one output channel
`timescale 1ns/1ps
module opl_level_slot (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_wr_imm,
    input wire logic [opl_pkg::LEVEL_W-1:0] i_imm,
    input wire logic i_wr_pend,
    input wire logic [opl_pkg::LEVEL_W-1:0] i_pend,
    input wire logic i_xfer,
    output logic [opl_pkg::LEVEL_W-1:0] o_imm,
    output logic [opl_pkg::LEVEL_W-1:0] o_pend
);
    import opl_pkg::*;

    typedef struct packed {
        logic [LEVEL_W-1:0] imm;
        logic [LEVEL_W-1:0] pend;
    } opl_slot_st_t;

    opl_slot_st_t q;
    opl_slot_st_t d;

    always_comb begin
        d = q;
        if (i_xfer) begin
            d.imm = q.pend;
        end
        // A direct write beats a trigger landing in the same cycle
        if (i_wr_imm) begin
            d.imm = i_imm;
        end
        if (i_wr_pend) begin
            d.pend = i_pend;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q.imm <= LEVEL_RESET;
            q.pend <= LEVEL_RESET;
        end else begin
            q <= d;
        end
    end

    assign o_imm = q.imm;
    assign o_pend = q.pend;

endmodule // opl_level_slot

// ==== hdl/opl_protect_ctrl.sv ====
// Output protection, remote inhibit and current level controller
//
// The implementer's own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module opl_protect_ctrl #(
    parameter int NCH = opl_pkg::NUM_CH,
    parameter int TICK_CYCLES = opl_pkg::TICK_CYCLES
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RESET_N,
    input wire opl_pkg::opl_avs_req_t I_AVS,
    output opl_pkg::opl_avs_rsp_t O_AVS,
    input wire logic [NCH-1:0] I_CC,
    input wire logic I_OV,
    input wire logic I_INHIBIT_N,
    input wire logic I_TRIGGER,
    input wire logic [1:0] I_NV_MODE,
    output logic O_NV_WR,
    output logic [1:0] O_NV_MODE,
    output logic O_OUT_EN,
    output logic [NCH-1:0] O_CC_REC,
    output logic O_OC_FLAG,
    output logic [NCH-1:0][opl_pkg::LEVEL_W-1:0] O_LEVEL,
    output logic O_IRQ
);
    import opl_pkg::*;

    localparam int TW = (TICK_CYCLES < 2) ? 1 : $clog2(TICK_CYCLES);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

    if (NCH < 1 || NCH > NUM_CH_MAX || TICK_CYCLES < 2) begin : g_bad_cfg
        $error("opl_protect_ctrl: unsupported NCH or TICK_CYCLES");
    end

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic waitreq;
        logic [31:0] rdata;
        logic [TW-1:0] tick_cnt;
        logic tick;
        logic nv_loaded;
        logic nv_wr;
        opl_ri_mode_t mode;
        logic ocp_en;
        logic out_on;
        logic [DELAY_W-1:0] delay;
        logic oc_trip;
        logic ov_trip;
        logic inh_latch;
        logic inh_prev;
        logic armed;
        logic out_en;
        logic [NCH-1:0] cc_prev;
        logic [EV_W-1:0] irq_stat;
        logic [EV_W-1:0] irq_en;
        logic irq;
    } opl_ctrl_st_t;

    opl_ctrl_st_t q;
    opl_ctrl_st_t d;

    logic req;
    logic acc;
    logic wr;
    logic [5:0] word_a;
    logic [31:0] wd;
    logic [3:0] be;
    logic inh_low;
    logic xfer;
    logic prog_chg;
    logic [NCH-1:0] cc_rec;
    logic [NCH-1:0] wr_imm;
    logic [NCH-1:0] wr_pend;
    logic [NCH-1:0][LEVEL_W-1:0] lv_imm;
    logic [NCH-1:0][LEVEL_W-1:0] lv_pend;
    logic [31:0] rd;
    logic [EV_W-1:0] ev;
    logic clear_cmd;
    logic arm_cmd;
    logic clr_ok;
    logic live_off;
    logic ctrl_wr;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    // A request is taken on the edge where waitrequest is already low,
    // which gives every access a fixed two-cycle shape
    assign req = I_AVS.read | I_AVS.write;
    assign acc = req & ~q.waitreq;
    assign wr = acc & I_AVS.write;
    assign word_a = {I_AVS.address[5:2], 2'b00};
    assign wd = I_AVS.writedata;
    assign be = I_AVS.byteenable;
    assign inh_low = ~I_INHIBIT_N;
    assign ctrl_wr = wr & (word_a == OFS_CTRL) & be[0];
    assign xfer = I_TRIGGER & q.armed;
    assign prog_chg = xfer | (|wr_imm) | ctrl_wr;

    ////////////////////////////////////////////////////////////////////////
    // Per-channel levels and constant-current qualification

    for (genvar g = 0; g < NCH; g++) begin : g_ch
        localparam logic [5:0] A_IMM = 6'(OFS_LEVEL + LEVEL_STRIDE * g);
        localparam logic [5:0] A_PEND = 6'(A_IMM + PEND_OFS);
        logic [31:0] m_imm;
        logic [31:0] m_pend;

        assign wr_imm[g] = wr & (word_a == A_IMM);
        assign wr_pend[g] = wr & (word_a == A_PEND);
        assign m_imm = be_merge(32'(lv_imm[g]), wd, be);
        assign m_pend = be_merge(32'(lv_pend[g]), wd, be);

        opl_level_slot u_slot (
            .i_clk(I_CORE_CLK),
            .i_reset_n(I_RESET_N),
            .i_wr_imm(wr_imm[g]),
            .i_imm(m_imm[LEVEL_W-1:0]),
            .i_wr_pend(wr_pend[g]),
            .i_pend(m_pend[LEVEL_W-1:0]),
            .i_xfer(xfer),
            .o_imm(lv_imm[g]),
            .o_pend(lv_pend[g])
        );

        opl_cc_delay u_dly (
            .i_clk(I_CORE_CLK),
            .i_reset_n(I_RESET_N),
            .i_tick(q.tick),
            .i_restart(prog_chg),
            .i_cc(I_CC[g]),
            .i_delay(q.delay),
            .o_rec(cc_rec[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        d = q;
        rd = '0;
        ev = '0;
        d.nv_wr = 1'b0;

        // Read mux, sampled one cycle before the access completes
        case (word_a)
            OFS_CTRL: begin
                rd[CTRL_OCP_EN] = q.ocp_en;
                rd[CTRL_MODE +: 2] = q.mode;
                rd[CTRL_OUT_ON] = q.out_on;
            end
            OFS_DELAY: begin
                rd[DELAY_W-1:0] = q.delay;
            end
            OFS_STATUS: begin
                rd[ST_OUT_EN] = q.out_en;
                rd[ST_OC] = q.oc_trip;
                rd[ST_OV] = q.ov_trip;
                rd[ST_INH_LATCH] = q.inh_latch;
                rd[ST_INH_IN] = inh_low;
                rd[ST_ARMED] = q.armed;
                rd[ST_CC +: NCH] = cc_rec;
            end
            OFS_IRQ_STAT: begin
                rd[EV_W-1:0] = q.irq_stat;
            end
            OFS_IRQ_EN: begin
                rd[EV_W-1:0] = q.irq_en;
            end
            default: begin
            end
        endcase
        for (int i = 0; i < NCH; i++) begin
            if (word_a == 6'(OFS_LEVEL + LEVEL_STRIDE * i)) begin
                rd[LEVEL_W-1:0] = lv_imm[i];
            end
            if (word_a == 6'(OFS_LEVEL + LEVEL_STRIDE * i + PEND_OFS)) begin
                rd[LEVEL_W-1:0] = lv_pend[i];
            end
        end

        // Fixed millisecond tick for the protection delay
        d.tick = (q.tick_cnt == TICK_LAST);
        d.tick_cnt = d.tick ? '0 : TW'(q.tick_cnt + 1'b1);

        // Stored mode is picked up once, on the first cycle after reset
        if (!q.nv_loaded) begin
            d.nv_loaded = 1'b1;
            d.mode = to_mode(I_NV_MODE);
        end

        // Register writes
        if (ctrl_wr) begin
            d.ocp_en = wd[CTRL_OCP_EN];
            d.out_on = wd[CTRL_OUT_ON];
            d.mode = to_mode(wd[CTRL_MODE +: 2]);
            d.nv_wr = (d.mode != q.mode);
        end
        if (wr && word_a == OFS_DELAY) begin
            d.delay = DELAY_W'(be_merge(32'(q.delay), wd, be));
        end
        if (wr && word_a == OFS_IRQ_EN && be[0]) begin
            d.irq_en = wd[EV_W-1:0];
        end
        clear_cmd = wr && word_a == OFS_CMD && be[0] && wd[CMD_CLEAR];
        arm_cmd = wr && word_a == OFS_CMD && be[0] && wd[CMD_ARM];

        // Clear only with inhibit released and no fault still present
        clr_ok = clear_cmd && !inh_low && !I_OV && !(|cc_rec);
        if (clr_ok) begin
            d.oc_trip = 1'b0;
            d.ov_trip = 1'b0;
            d.inh_latch = 1'b0;
        end

        // Fault sets come after the clear so a same-cycle event wins
        if (I_OV) begin
            d.ov_trip = 1'b1;
        end
        if (q.ocp_en && (|cc_rec)) begin
            d.oc_trip = 1'b1;
        end
        if (q.mode == RI_LATCH && inh_low) begin
            d.inh_latch = 1'b1;
        end
        // Off mode never reaches the gate below
        live_off = (q.mode == RI_LIVE) && inh_low;

        // The user's on/off choice is never touched by a fault, so a
        // successful clear brings back whatever was set before
        d.out_en = d.out_on & ~d.oc_trip & ~d.ov_trip & ~d.inh_latch
                   & ~live_off;

        // Trigger arming is one-shot
        if (xfer) begin
            d.armed = 1'b0;
        end
        if (arm_cmd) begin
            d.armed = 1'b1;
        end

        // Events and interrupt
        ev[EV_CC] = |(cc_rec & ~q.cc_prev);
        ev[EV_OC] = d.oc_trip & ~q.oc_trip;
        ev[EV_INH] = (q.mode != RI_OFF) & inh_low & ~q.inh_prev;
        ev[EV_TRIG] = xfer;
        d.cc_prev = cc_rec;
        d.inh_prev = inh_low;
        if (wr && word_a == OFS_IRQ_CLR && be[0]) begin
            d.irq_stat = q.irq_stat & ~wd[EV_W-1:0];
        end
        d.irq_stat = d.irq_stat | ev;
        d.irq = |(d.irq_stat & d.irq_en);

        // Bus handshake
        d.waitreq = ~(req & q.waitreq);
        if (req && q.waitreq) begin
            d.rdata = rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            q <= '0;
            q.waitreq <= 1'b1;
            q.delay <= DELAY_RESET;
            q.mode <= RI_OFF;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign O_AVS.readdata = q.rdata;
    assign O_AVS.waitrequest = q.waitreq;
    assign O_NV_WR = q.nv_wr;
    assign O_NV_MODE = q.mode;
    assign O_OUT_EN = q.out_en;
    assign O_CC_REC = cc_rec;
    assign O_OC_FLAG = q.oc_trip;
    assign O_LEVEL = lv_imm;
    assign O_IRQ = q.irq;

endmodule // opl_protect_ctrl

// ==== tb/opl_load_model.sv ====
// Load model standing beside the output stage: demand versus limit
`timescale 1ns/1ps
module opl_load_model #(
    parameter int NCH = 2
) (
    input wire logic [NCH-1:0][15:0] i_level,
    input wire logic [NCH-1:0][15:0] i_demand,
    output logic [NCH-1:0] o_cc
);
    // Constant current begins once the demand reaches the limit
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            o_cc[c] = i_demand[c] >= i_level[c];
        end
    end
endmodule // opl_load_model

// ==== tb/opl_checker.sv ====
// Port assertions for the protection controller
`timescale 1ns/1ps
module opl_checker #(
    parameter int NCH = 2
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RESET_N,
    input wire opl_pkg::opl_avs_req_t I_AVS,
    input wire opl_pkg::opl_avs_rsp_t O_AVS,
    input wire logic [NCH-1:0] I_CC,
    input wire logic I_OV,
    input wire logic I_INHIBIT_N,
    input wire logic I_TRIGGER,
    input wire logic O_NV_WR,
    input wire logic [1:0] O_NV_MODE,
    input wire logic O_OUT_EN,
    input wire logic [NCH-1:0] O_CC_REC,
    input wire logic O_OC_FLAG,
    input wire logic [NCH-1:0][opl_pkg::LEVEL_W-1:0] O_LEVEL
);
    import opl_pkg::*;
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RESET_N);
    logic clr_acc;
    assign clr_acc = I_AVS.write && !O_AVS.waitrequest &&
        I_AVS.byteenable[0] && I_AVS.writedata[CMD_CLEAR] &&
        (I_AVS.address[5:2] == OFS_CMD[5:2]);
    ////////////////////////////////////////
    AST_OV_NOW: assert property (I_OV |=> !O_OUT_EN)
        else $error("output stayed on during overvoltage");
    AST_LIVE: assert property ((O_NV_MODE == RI_LIVE) && !I_INHIBIT_N
        |=> !O_OUT_EN) else $error("live inhibit ignored");
    AST_LATCH: assert property ((O_NV_MODE == RI_LATCH) && !I_INHIBIT_N
        |=> !O_OUT_EN) else $error("latching inhibit ignored");
    AST_CC_SRC: assert property ($rose(O_CC_REC[1]) |-> $past(I_CC[1]))
        else $error("cc recorded without cc input");
    AST_CC_DROP: assert property (!I_CC[1] |=> !O_CC_REC[1])
        else $error("cc record outlived its cause");
    AST_OC_SRC: assert property ($rose(O_OC_FLAG) |-> $past(|O_CC_REC))
        else $error("overcurrent trip without recorded cc");
    AST_OC_OFF: assert property ($rose(O_OC_FLAG) |-> !O_OUT_EN)
        else $error("overcurrent trip left output on");
    AST_OC_HOLD: assert property (O_OC_FLAG && !clr_acc |=> O_OC_FLAG)
        else $error("overcurrent flag dropped without clear");
    AST_CLR_REF: assert property (O_OC_FLAG && clr_acc && I_OV
        |=> O_OC_FLAG) else $error("clear accepted with fault present");
    AST_NV_PULSE: assert property (O_NV_WR |=> !O_NV_WR)
        else $error("store strobe longer than one cycle");
    AST_LVL_SRC: assert property ($changed(O_LEVEL)
        |-> $past(I_TRIGGER) || $past(I_AVS.write))
        else $error("level changed without trigger or write");
endmodule // opl_checker

bind opl_protect_ctrl opl_checker #(.NCH(NCH)) u_chk (
    .I_CORE_CLK(I_CORE_CLK), .I_RESET_N(I_RESET_N), .I_AVS(I_AVS),
    .O_AVS(O_AVS), .I_CC(I_CC), .I_OV(I_OV), .I_INHIBIT_N(I_INHIBIT_N),
    .I_TRIGGER(I_TRIGGER), .O_NV_WR(O_NV_WR), .O_NV_MODE(O_NV_MODE),
    .O_OUT_EN(O_OUT_EN), .O_CC_REC(O_CC_REC), .O_OC_FLAG(O_OC_FLAG),
    .O_LEVEL(O_LEVEL));

// ==== tb/opl_protect_ctrl_tb.sv ====
// Self-checking testbench for the protection controller
`timescale 1ns/1ps
module opl_protect_ctrl_tb;
    import opl_pkg::*;
    logic clk = 0, rst_n = 0, ov = 0, inh_n = 1, trig = 0, seen;
    logic [1:0] nv = 2'h2;
    logic [NUM_CH-1:0][15:0] dem = '0;
    logic [NUM_CH-1:0][15:0] lvl;
    logic [NUM_CH-1:0] cc, cc_rec;
    opl_avs_req_t avs = '0;
    opl_avs_rsp_t rsp;
    logic nv_wr, out_en, oc, irq;
    logic [1:0] nv_mode;
    logic [31:0] exp_q[$];
    logic [31:0] seed = 32'h9898;
    logic [15:0] p0, p1;
    int bad_count = 0, n_tests = 0, n;

    opl_protect_ctrl #(.NCH(NUM_CH), .TICK_CYCLES(4)) u_dut (
        .I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_AVS(avs), .O_AVS(rsp),
        .I_CC(cc), .I_OV(ov), .I_INHIBIT_N(inh_n), .I_TRIGGER(trig),
        .I_NV_MODE(nv), .O_NV_WR(nv_wr), .O_NV_MODE(nv_mode),
        .O_OUT_EN(out_en), .O_CC_REC(cc_rec), .O_OC_FLAG(oc),
        .O_LEVEL(lvl), .O_IRQ(irq));
    opl_load_model #(.NCH(NUM_CH)) u_load (.i_level(lvl), .i_demand(dem),
        .o_cc(cc));

    always #12.5 clk = ~clk;
    ////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic chk(input string what, input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic end_sim;
        $display("TB: %0d checks, %0d mismatches", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Request held until the rising edge that sees waitrequest low,
    // released right after that same edge
    task automatic bus(input logic r, input logic [5:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge clk);
        avs <= '{r, !r, a, 4'hf, d};
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (rsp.waitrequest === 1'b0) break;
        end
        if (i == 16) begin
            bad_count++;
            end_sim();
        end
        avs.read <= 1'b0;
        avs.write <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b0, a, d);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b1, a, 32'h0);
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic pulse_trig;
        @(posedge clk) trig <= 1'b1;
        @(posedge clk) trig <= 1'b0;
        tick(2);
    endtask
    task automatic set_inh(input logic v);
        @(posedge clk) inh_n <= v;
        tick(2);
    endtask

    // Read data are taken at the same rising edge that completes the read
    always @(posedge clk) begin
        if (avs.read && rsp.waitrequest === 1'b0) begin
            if (exp_q.size() == 0)
                chk("unexpected read", 32'h1, 32'h0);
            else
                chk("readdata", rsp.readdata, exp_q.pop_front());
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        end_sim();
    end

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        tick(2);
        chk("nv mode", nv_mode, 2'h2);
        chk("level0", lvl[0], 16'h1999);
        chk("level1", lvl[1], 16'h1999);
        rd(OFS_DELAY, 32'h50);
        rd(6'h1c, 32'h0);
        $display("TB: reset test done");
        wr(OFS_IRQ_EN, 32'h4);
        wr(OFS_CTRL, 32'hc);
        tick(2);
        chk("out on", out_en, 1'b1);
        set_inh(1'b0);
        chk("irq", irq, 1'b1);
        wr(OFS_CMD, 32'h1);
        set_inh(1'b1);
        chk("latched", out_en, 1'b0);
        wr(OFS_IRQ_EN, 32'h0);
        tick(2);
        chk("irq masked", irq, 1'b0);
        rd(OFS_IRQ_STAT, 32'h4);
        wr(OFS_IRQ_CLR, 32'h4);
        rd(OFS_IRQ_STAT, 32'h0);
        wr(OFS_CMD, 32'h1);
        tick(2);
        chk("released", out_en, 1'b1);
        $display("TB: latching test done");
        wr(OFS_CTRL, 32'ha);
        seen = 1'b0;
        repeat (4) begin
            @(negedge clk);
            seen |= nv_wr;
        end
        chk("nv store", seen, 1'b1);
        chk("nv mode", nv_mode, 2'h1);
        set_inh(1'b0);
        chk("live low", out_en, 1'b0);
        set_inh(1'b1);
        chk("live high", out_en, 1'b1);
        wr(OFS_CTRL, 32'h8);
        set_inh(1'b0);
        tick(1);
        chk("mode off", out_en, 1'b1);
        set_inh(1'b1);
        $display("TB: inhibit modes done");
        seed = xs(seed);
        p0 = seed[15:0] | 16'h0100;
        p1 = seed[31:16] | 16'h0100;
        wr(6'h24, {16'h0, p0});
        wr(6'h2c, {16'h0, p1});
        pulse_trig();
        chk("unarmed", lvl[0], 16'h1999);
        wr(OFS_CMD, 32'h2);
        pulse_trig();
        chk("main xfer", lvl[0], p0);
        chk("aux xfer", lvl[1], p1);
        rd(6'h20, {16'h0, p0});
        wr(6'h24, {16'h0, ~p0});
        pulse_trig();
        chk("arm used", lvl[0], p0);
        $display("TB: trigger test done");
        wr(OFS_DELAY, 32'h3);
        wr(OFS_CTRL, 32'h9);
        rd(OFS_CTRL, 32'h9);
        @(posedge clk) dem[1] <= 16'hffff;
        seen = 1'b0;
        repeat (10) begin
            @(negedge clk);
            seen |= cc_rec[1];
        end
        @(posedge clk) dem[1] <= 16'h0;
        tick(3);
        chk("transient", seen | oc, 1'b0);
        @(posedge clk) dem[1] <= 16'hffff;
        n = 0;
        while (cc_rec[1] !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk("cc delay", n >= 12 && n <= 20, 1'b1);
        tick(2);
        chk("oc flag", oc, 1'b1);
        chk("oc off", out_en, 1'b0);
        rd(OFS_STATUS, 32'h202);
        wr(OFS_CMD, 32'h1);
        tick(2);
        chk("oc held", oc, 1'b1);
        @(posedge clk) dem[1] <= 16'h0;
        tick(3);
        wr(OFS_CMD, 32'h1);
        tick(2);
        chk("oc cleared", oc, 1'b0);
        chk("restored", out_en, 1'b1);
        $display("TB: overcurrent test done");
        @(posedge clk) ov <= 1'b1;
        @(posedge clk) ov <= 1'b0;
        tick(1);
        chk("ov off", out_en, 1'b0);
        wr(OFS_CMD, 32'h1);
        tick(2);
        chk("ov cleared", out_en, 1'b1);
        $display("TB: overvoltage test done");
        @(posedge clk);
        nv <= 2'h1;
        rst_n <= 1'b0;
        tick(2);
        @(posedge clk) rst_n <= 1'b1;
        tick(2);
        chk("nv reload", nv_mode, 2'h1);
        chk("level reset", lvl[0], 16'h1999);
        $display("TB: second reset done");
        end_sim();
    end
endmodule // opl_protect_ctrl_tb
